/* bench/data_space_access_unit_tb.sv */
`default_nettype none
module data_space_access_unit_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic clock_in = 0, resetn_in = 0, read_req_in = 0, read_byte_in = 0, write_req_in = 0;
    logic write_byte_in = 0, sfr_hit_in, read_valid_out, sfr_re_out, address_error_trap_out;
    logic [1:0] read_mode_in = '0, read_ext_in = '0, write_mode_in = '0, sfr_lane_we_out;
    logic [15:0] read_direct_in = '0, read_pointer_in = '0, read_dest_old_in = '0;
    logic [15:0] write_direct_in = '0, write_pointer_in = '0, write_data_in = '0, sfr_rdata_in;
    logic [15:0] read_data_out, read_dest_out, read_pointer_out, write_pointer_out;
    logic [15:0] sfr_addr_out, sfr_wdata_out;
    int mismatches = 0, cmp_count = 0;
    logic [15:0] zaddr [4] = '{16'h7800, 16'h8000, 16'hFFFE, 16'h0100};
    always #5 clock_in = ~clock_in;
    data_space_access_unit u_data_space_access_unit (.*);
    sfr_space_model u_sfr_space_model (.clock_in(clock_in), .look_in(read_direct_in),
        .addr_in(sfr_addr_out), .wdata_in(sfr_wdata_out), .lane_we_in(sfr_lane_we_out),
        .rdata_out(sfr_rdata_in), .hit_out(sfr_hit_in));
    task automatic check(input string n, input logic [15:0] s, e);
        cmp_count++;
        if (s !== e) begin
            mismatches++;
            $display("[ERR] %s expected %h seen %h", n, e, s);
        end
    endtask
    // Requests change only at the falling edge; results of the taking edge are read there.
    task automatic cyc(input logic r, w);
        read_req_in = r;
        write_req_in = w;
        @(negedge clock_in);
    endtask
    task automatic rdx(input logic b, input logic [1:0] m, input logic [15:0] a);
        {read_byte_in, read_mode_in, read_direct_in, read_pointer_in} = {b, m, a, a};
        cyc(1, 0);
    endtask
    task automatic wrx(input logic b, input logic [1:0] m, input logic [15:0] a, d);
        {write_byte_in, write_mode_in, write_direct_in, write_pointer_in, write_data_in} = {b, m, a, a, d};
        cyc(0, 1);
    endtask
    task automatic summarize();
        $display("compares %0d mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    initial begin
        #100000;
        mismatches++;
        summarize();
    end
    initial begin
        repeat (16) @(negedge clock_in);
        resetn_in = 1;
        repeat (3) @(negedge clock_in);
        wrx(0, 2'h0, 16'h0800, 16'h1234);
        wrx(1, 2'h0, 16'h0801, 16'h00AB);
        rdx(0, 2'h0, 16'h0800); check("word", read_data_out, 16'hAB34);
        rdx(1, 2'h0, 16'h0801); check("hi byte", read_data_out, 16'h00AB);
        rdx(1, 2'h0, 16'h0800); check("lo byte", read_data_out, 16'h0034);
        // Give the word behind the odd write a known value first.
        wrx(0, 2'h0, 16'h0802, 16'h1111);
        wrx(0, 2'h0, 16'h0803, 16'h5555); check("wtrap", address_error_trap_out, 16'h1);
        rdx(0, 2'h0, 16'h0801); check("rtrap", address_error_trap_out, 16'h1);
        check("rvalid", read_valid_out, 16'h1);
        rdx(0, 2'h0, 16'h0802); check("no write", read_data_out, 16'h1111);
        check("trap gone", address_error_trap_out, 16'h0);
        wrx(0, 2'h0, 16'h0053, 16'h7777); check("odd lanes", sfr_lane_we_out, 16'h0);
        $display("lanes and misalign done");
        foreach (zaddr[i]) begin
            rdx(0, 2'h0, zaddr[i]);
            check("zero fill", read_data_out, 16'h0000);
        end
        wrx(0, 2'h0, 16'h0804, 16'h80F0);
        read_dest_old_in = 16'hABCD;
        for (int e = 0; e < 3; e++) begin
            read_ext_in = e[1:0];
            rdx(1, 2'h0, 16'h0804);
            check("extend", read_dest_out, e == 0 ? 16'hABF0 : e == 1 ? 16'hFFF0 : 16'h00F0);
        end
        read_ext_in = 2'h0;
        $display("zero and extend done");
        rdx(1, 2'h3, 16'h0804); check("ptr byte", read_pointer_out, 16'h0805);
        {read_byte_in, write_byte_in, write_mode_in, write_pointer_in} = {2'b00, 2'h3, 16'h0900};
        cyc(1, 1); check("ptr word", read_pointer_out, 16'h0806);
        check("wptr", write_pointer_out, 16'h0902);
        rdx(0, 2'h1, 16'hE804); check("near", read_data_out, 16'h80F0);
        wrx(1, 2'h0, 16'h0051, 16'h005A); check("lane", sfr_lane_we_out, 16'h2);
        check("sfr addr", sfr_addr_out, 16'h0051);
        check("sfr wdata", sfr_wdata_out, 16'h5A5A);
        cyc(0, 0);
        rdx(0, 2'h0, 16'h0050); check("sfr read", read_data_out, 16'h5A00);
        check("sfr re", sfr_re_out, 16'h1);
        cyc(0, 0);
        $display("pointer and control space done");
        summarize();
    end
endmodule
`default_nettype wire

/* bench/data_space_monitor.sv */
`default_nettype none
module data_space_monitor (
    input wire logic clock_in, resetn_in, read_req_in, read_byte_in, write_req_in,
    input wire logic write_byte_in, read_valid_out, address_error_trap_out,
    input wire logic [1:0] read_mode_in, read_ext_in, write_mode_in, sfr_lane_we_out,
    input wire logic [15:0] read_direct_in, read_pointer_in, write_direct_in,
    input wire logic [15:0] read_data_out, read_dest_out, read_pointer_out
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge clock_in); endclocking
    default disable iff (!resetn_in);
    wire rd_odd = read_req_in && !read_byte_in && read_mode_in == 2'h0 && read_direct_in[0];
    wire wr_odd = write_req_in && !write_byte_in && write_mode_in == 2'h0 && write_direct_in[0];
    wire wr_hi = write_direct_in[0];
    chk_trap_on_odd: assert property ((rd_odd || wr_odd) |=> address_error_trap_out)
        else $error("trap missing");
    chk_trap_quiet: assert property (!(read_req_in || write_req_in) |=> !address_error_trap_out)
        else $error("trap without access");
    chk_read_answer: assert property (read_req_in |=> read_valid_out)
        else $error("read not answered");
    chk_odd_write_held: assert property (wr_odd |=> sfr_lane_we_out == 2'h0)
        else $error("odd write landed");
    chk_byte_lane_pick: assert property (write_req_in && write_byte_in && write_mode_in == 2'h0
        && write_direct_in <= 16'h07FF |=> sfr_lane_we_out == ($past(wr_hi) ? 2'h2 : 2'h1))
        else $error("wrong lane");
    chk_postinc_step: assert property (read_req_in && read_mode_in == 2'h3 |=> read_pointer_out
        == $past(read_pointer_in) + ($past(read_byte_in) ? 16'h0001 : 16'h0002))
        else $error("pointer step");
    chk_byte_low_lane: assert property (read_req_in && read_byte_in |=> read_data_out[15:8] == 8'h00)
        else $error("byte not on low lane");
    chk_zero_ext_high: assert property (read_req_in && read_byte_in && read_ext_in == 2'h2
        |=> read_dest_out[15:8] == 8'h00)
        else $error("zero extend");
    chk_upper_half_zero: assert property (read_req_in && read_mode_in == 2'h0 && read_direct_in[15]
        |=> read_data_out == 16'h0000)
        else $error("upper half not zero");
endmodule
bind data_space_access_unit data_space_monitor u_data_space_monitor (.*);
`default_nettype wire

/* bench/sfr_space_model.sv */
`default_nettype none
module sfr_space_model (
    input wire logic clock_in,
    input wire logic [15:0] look_in,
    input wire logic [15:0] addr_in,
    input wire logic [15:0] wdata_in,
    input wire logic [1:0] lane_we_in,
    output logic [15:0] rdata_out,
    output logic hit_out
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [15:0] word_r = 16'h0000;
    wire sel = addr_in[15:1] == 15'h0028;
    assign hit_out = look_in[15:1] == 15'h0028;
    // Unused places show the inverse word, so a missing zero fill in the design shows up.
    assign rdata_out = hit_out ? word_r : ~word_r;
    always @(posedge clock_in) begin
        if (sel && lane_we_in[0]) word_r[7:0] <= wdata_in[7:0];
        if (sel && lane_we_in[1]) word_r[15:8] <= wdata_in[15:8];
    end
endmodule
`default_nettype wire

/* src/address_generation_unit.v */
`default_nettype none
`include "data_space_consts.vh"
module address_generation_unit (
    // Addressing request.
    input wire [1:0] mode_in,
    input wire [15:0] direct_addr_in,
    input wire [15:0] pointer_in,
    input wire byte_op_in,
    // Formed address.
    output wire [15:0] effective_address_out,
    output wire [15:0] pointer_nxt_out
);
    wire [15:0] near_addr;
    wire [15:0] step;
    assign near_addr = {3'h0, direct_addr_in[`NEAR_W-1:0]};
    assign effective_address_out = (mode_in == `MODE_NEAR) ? near_addr :
        (mode_in == `MODE_DIRECT) ? direct_addr_in : pointer_in;
    assign step = byte_op_in ? 16'h0001 : 16'h0002;
    assign pointer_nxt_out = (mode_in == `MODE_POSTINC) ? pointer_in + step : pointer_in;
endmodule
`default_nettype wire

/* src/data_space_access_unit.v */
`default_nettype none
`include "data_space_consts.vh"
module data_space_access_unit (
    // Clock and reset.
    input wire clock_in,
    input wire resetn_in,
    // Read side.
    input wire read_req_in,
    input wire read_byte_in,
    input wire [1:0] read_mode_in,
    input wire [15:0] read_direct_in,
    input wire [15:0] read_pointer_in,
    input wire [1:0] read_ext_in,
    input wire [15:0] read_dest_old_in,
    // Write side.
    input wire write_req_in,
    input wire write_byte_in,
    input wire [1:0] write_mode_in,
    input wire [15:0] write_direct_in,
    input wire [15:0] write_pointer_in,
    input wire [15:0] write_data_in,
    // Special function register space.
    input wire [15:0] sfr_rdata_in,
    input wire sfr_hit_in,
    // Results.
    output wire read_valid_out,
    output wire [15:0] read_data_out,
    output wire [15:0] read_dest_out,
    output wire [15:0] read_pointer_out,
    output wire [15:0] write_pointer_out,
    output wire [15:0] sfr_addr_out,
    output wire [1:0] sfr_lane_we_out,
    output wire [15:0] sfr_wdata_out,
    output wire sfr_re_out,
    output wire address_error_trap_out
);
    reg rst_meta_r;
    reg rst_sync_r;
    always @(posedge clock_in or negedge resetn_in) begin
        if (!resetn_in) begin
            rst_meta_r <= 1'b0;
            rst_sync_r <= 1'b0;
        end else begin
            rst_meta_r <= 1'b1;
            rst_sync_r <= rst_meta_r;
        end
    end
    wire rst_n = rst_sync_r;

    wire [15:0] rd_ea;
    wire [15:0] wr_ea;
    wire [15:0] rd_ptr_nxt;
    wire [15:0] wr_ptr_nxt;
    // Two instances keep read and write address formation apart.
    address_generation_unit rd_agu (
        .mode_in(read_mode_in),
        .direct_addr_in(read_direct_in),
        .pointer_in(read_pointer_in),
        .byte_op_in(read_byte_in),
        .effective_address_out(rd_ea),
        .pointer_nxt_out(rd_ptr_nxt)
    );
    address_generation_unit wr_agu (
        .mode_in(write_mode_in),
        .direct_addr_in(write_direct_in),
        .pointer_in(write_pointer_in),
        .byte_op_in(write_byte_in),
        .effective_address_out(wr_ea),
        .pointer_nxt_out(wr_ptr_nxt)
    );

    // Two byte lanes sharing one word index.
    reg [7:0] lane_lo_r [0:`MEM_WORDS-1];
    reg [7:0] lane_hi_r [0:`MEM_WORDS-1];

    wire rd_mis = read_req_in & ~read_byte_in & rd_ea[0];
    wire wr_mis = write_req_in & ~write_byte_in & wr_ea[0];
    wire rd_mem = ~rd_ea[`IMPL_BIT] & (rd_ea > `SFR_TOP_BYTE) & (rd_ea <= `MEM_TOP_BYTE);
    wire wr_mem = ~wr_ea[`IMPL_BIT] & (wr_ea > `SFR_TOP_BYTE) & (wr_ea <= `MEM_TOP_BYTE);
    wire rd_sfr = rd_ea <= `SFR_TOP_BYTE;
    wire wr_sfr = wr_ea <= `SFR_TOP_BYTE;
    // Byte address down to a word index; bit 0 only picks the lane.
    wire [13:0] rd_idx = rd_ea[14:1];
    wire [13:0] wr_idx = wr_ea[14:1];

    // Write suppressed when misaligned; instruction still completes.
    wire wr_go = write_req_in & ~wr_mis;
    // Low byte at even address, high byte at odd.
    wire we_lo = wr_go & (~write_byte_in | ~wr_ea[0]);
    wire we_hi = wr_go & (~write_byte_in | wr_ea[0]);
    wire [7:0] wbyte = write_data_in[7:0];
    wire [7:0] wlo = write_data_in[7:0];
    wire [7:0] whi = write_byte_in ? wbyte : write_data_in[15:8];

    always @(posedge clock_in) begin
        if (wr_mem & we_lo) begin
            lane_lo_r[wr_idx] <= wlo;
        end
        if (wr_mem & we_hi) begin
            lane_hi_r[wr_idx] <= whi;
        end
    end

    // Whole word fetched; unimplemented space reads zero.
    wire [15:0] mem_word = rd_mem ? {lane_hi_r[rd_idx], lane_lo_r[rd_idx]} : `RESET_DATA;
    // Unused control addresses read zero.
    wire [15:0] sfr_word = (rd_sfr & sfr_hit_in) ? sfr_rdata_in : `RESET_DATA;
    wire [15:0] word = rd_sfr ? sfr_word : mem_word;
    // Byte chosen by bit 0, placed on the low lane.
    wire [7:0] sel_byte = rd_ea[0] ? word[15:8] : word[7:0];
    wire [15:0] rdata = read_byte_in ? {8'h00, sel_byte} : word;

    reg [15:0] dest_nxt;
    always @* begin
        dest_nxt = rdata;
        if (read_byte_in) begin
            case (read_ext_in)
                `EXT_SIGN: dest_nxt = {{8{sel_byte[7]}}, sel_byte};
                `EXT_ZERO: dest_nxt = {8'h00, sel_byte};
                default: dest_nxt = {read_dest_old_in[15:8], sel_byte};
            endcase
        end
    end

    reg valid_r;
    reg [15:0] rdata_r;
    reg [15:0] dest_r;
    reg [15:0] rptr_r;
    reg [15:0] wptr_r;
    reg [15:0] sfr_addr_r;
    reg [1:0] sfr_we_r;
    reg [15:0] sfr_wdata_r;
    reg sfr_re_r;
    reg trap_r;
    always @(posedge clock_in or negedge rst_n) begin
        if (!rst_n) begin
            valid_r <= 1'b0;
            rdata_r <= `RESET_DATA;
            dest_r <= `RESET_DATA;
            rptr_r <= `RESET_DATA;
            wptr_r <= `RESET_DATA;
            sfr_addr_r <= `RESET_DATA;
            sfr_we_r <= 2'h0;
            sfr_wdata_r <= `RESET_DATA;
            sfr_re_r <= 1'b0;
            trap_r <= 1'b0;
        end else begin
            valid_r <= read_req_in;
            rdata_r <= rdata;
            dest_r <= dest_nxt;
            rptr_r <= rd_ptr_nxt;
            wptr_r <= wr_ptr_nxt;
            sfr_addr_r <= wr_go ? wr_ea : rd_ea;
            sfr_we_r <= {we_hi & wr_sfr, we_lo & wr_sfr};
            sfr_wdata_r <= {whi, wlo};
            sfr_re_r <= read_req_in & rd_sfr;
            trap_r <= rd_mis | wr_mis;
        end
    end

    assign read_valid_out = valid_r;
    assign read_data_out = rdata_r;
    assign read_dest_out = dest_r;
    assign read_pointer_out = rptr_r;
    assign write_pointer_out = wptr_r;
    assign sfr_addr_out = sfr_addr_r;
    assign sfr_lane_we_out = sfr_we_r;
    assign sfr_wdata_out = sfr_wdata_r;
    assign sfr_re_out = sfr_re_r;
    assign address_error_trap_out = trap_r;
endmodule
`default_nettype wire

/* src/data_space_consts.vh */
// What this block does
// - Every data address is a 16-bit byte address: 64 Kbytes, 32K words.
// - Top address bit clear maps to memory; set reads as all zeros.
// - Up to 30 Kbytes implemented; reads outside return all zeros.
// - Low byte sits at the even address, high byte at the odd one.
// - Post-increment pointer steps by one for bytes, two for words.
// - Byte read fetches the word, bit 0 picks byte, delivered low.
// - Two byte lanes, shared word decode, separate write strobes per lane.
// - Word access at an odd address raises an address error trap.
// - Misaligned read completes; misaligned write is suppressed; trap follows.
// - Byte load into a working register changes only its low byte.
// - Sign-extend byte to word, and zero-extend clearing the high byte.
// - First 2 Kbytes, 0x0000 to 0x07FF, decode as control registers.
// - Unused control register addresses read as zero.
// - Region 0x0000 to 0x1FFF reachable by a 13-bit direct address.
// - Whole space reachable by 16-bit direct or register indirect address.
// - Read and write addresses are generated on independent paths.
`ifndef DATA_SPACE_CONSTS_VH
`define DATA_SPACE_CONSTS_VH
`define ADDR_W 16
`define WORD_W 16
`define WORD_ADDR_W 14
`define MEM_WORDS 15360
`define MEM_TOP_BYTE 16'h77FF
`define SFR_TOP_BYTE 16'h07FF
`define NEAR_W 13
`define IMPL_BIT 15
`define RESET_DATA 16'h0000
`define MODE_DIRECT 2'h0
`define MODE_NEAR 2'h1
`define MODE_INDIRECT 2'h2
`define MODE_POSTINC 2'h3
`define EXT_NONE 2'h0
`define EXT_SIGN 2'h1
`define EXT_ZERO 2'h2
`endif
